// >>> hw/ipei_ctrl.sv
// Purpose: Interrupt priority, external pins, timer0, port change, context
// Assumes: One clock, AHB-Lite register slave, sources on same clock
// Notes: Pins ext_pins and portb_pins are synchronised with three flops
// Operation
// - Peripheral priority bit one means high, zero low, resets to one.
// - Second priority register layout, bits 7 and 5 read zero.
// - Third priority register layout, bits 7-6 read zero.
// - Bit 7 of reset-cause register enables two levels, else single level.
// - Reset-cause flags layout, access kinds and reset values.
// - External pins are edge triggered, polarity from edge-select bit.
// - Valid edge sets pin flag; cleared enable blocks the interrupt.
// - Enabled external flag wakes core; high vectoring needs global enable, low vectoring needs peripheral enable.
// - Ext1..3 priorities come from their control register bits.
// - External interrupt zero is always high priority.
// - Timer0 flag set on 8-bit or 16-bit wrap.
// - Timer0 enable and priority bits in main and second control.
// - Port-B upper nibble change sets flag; enable and priority bits.
// - Accepted interrupt pushes return address on hardware stack.
// - Accepted interrupt copies working, status, bank to shadow.
// - Without priority levels, peripherals also need peripheral enable.
// - Peripheral priority bits ignored while priority enable clear.
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module ipei_ctrl
#(
   parameter int PC_W = 21,
   parameter int STACK_D = 31
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [3:0] ext_pins,
   input wire logic [7:4] portb_pins,
   input wire logic [7:4] portb_is_input,
   input wire logic timer0_tick,
   input wire logic [7:0] periph2_flags,
   input wire logic [7:0] periph2_enables,
   input wire logic [7:0] periph3_flags,
   input wire logic [7:0] periph3_enables,
   input wire logic core_accept,
   input wire logic core_return,
   input wire logic [PC_W-1:0] core_pc,
   input wire ipei_pkg::ipei_ctx_s core_ctx,
   output logic irq_high_q,
   output logic irq_low_q,
   output logic wake_q,
   output logic irq_q,
   output logic [PC_W-1:0] stack_top_q,
   output ipei_pkg::ipei_ctx_s shadow_q
);
   import ipei_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam int SP_W = $clog2(STACK_D + 1);
   logic [7:0] prio2_q, prio3_q, rcause_q, main_q, ctl2_q, ctl3_q;
   logic [EV_N-1:0] flag_q, mask_q, ev_set, ev_clr;
   logic t0_wide_q;
   logic [15:0] t0_cnt_q;
   logic [7:4] pb_snap_q;
   logic [3:0] x_s1_q, x_s2_q, x_s3_q, x_stable_q, x_edge;
   logic [7:4] pb_s1_q, pb_s2_q, pb_s3_q;
   logic [3:0] edge_sel, x_en;
   logic pb_mismatch, t0_wrap;
   ipei_req_s req_q;
   logic take, wr_go, rd_go;
   logic [7:0] wsel;
   logic [31:0] rdata;
   logic [PC_W-1:0] stack_q [STACK_D];
   logic [SP_W-1:0] sp_q;
   logic [EV_N-1:0] src_prio, src_en, src_act;
   logic [7:0] p2_act, p3_act;
   logic hi_d, lo_d, priority_levels_enable;

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   // Address phase taken on NONSEQ or SEQ with hready high
   assign take = hsel && htrans[1] && hready;
   assign wr_go = req_q.wr;
   assign rd_go = req_q.rd;
   assign wsel = req_q.addr;

   // Capture the address phase; reads insert one wait state
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         req_q <= '0;
         hreadyout <= 1'b1;
      end
      else if (clock_en)
      begin
         req_q.wr <= take && hwrite;
         req_q.rd <= take && !hwrite;
         if (take)
            req_q.addr <= {haddr[7:2], 2'b00};
         hreadyout <= !(take && !hwrite);
      end
   end

   // Read mux over the register map
   always_comb
   begin
      rdata = '0;
      case (wsel)
         OFS_PRIO2: rdata[7:0] = prio2_q;
         OFS_PRIO3: rdata[7:0] = prio3_q;
         OFS_RCAUSE: rdata[7:0] = rcause_q;
         OFS_MAIN:
            rdata[7:0] = {main_q[7:3], flag_q[EV_T0], flag_q[EV_X0],
                          flag_q[EV_PB]};
         OFS_CTL2: rdata[7:0] = ctl2_q;
         OFS_CTL3: rdata[7:0] = {ctl3_q[7:3], flag_q[EV_N-1:EV_X1]};
         OFS_STAT: rdata[EV_N-1:0] = flag_q;
         OFS_MASK: rdata[EV_N-1:0] = mask_q;
         OFS_T0CFG: rdata[0] = t0_wide_q;
         OFS_T0CNT: rdata[15:0] = t0_cnt_q;
         OFS_PBSNAP: rdata[7:4] = pb_snap_q;
         default: rdata = '0;
      endcase
   end

   // Read data registered in the wait state; response always OKAY
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         hrdata <= '0;
         hresp <= 1'b0;
      end
      else if (clock_en && rd_go)
         hrdata <= rdata;
   end

   // ----------------------------------------
   // Priority and reset-cause registers
   // ----------------------------------------
   // priorities
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         prio2_q <= PRIO2_IMPL;
         prio3_q <= PRIO3_IMPL;
      end
      else if (clock_en && wr_go)
      begin
         if (wsel == OFS_PRIO2)
            prio2_q <= hwdata[7:0] & PRIO2_IMPL;
         if (wsel == OFS_PRIO3)
            prio3_q <= hwdata[7:0] & PRIO3_IMPL;
      end
   end

   // reset-cause, watchdog and power-down bits read-only
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         rcause_q <= RCAUSE_RST;
      else if (clock_en && wr_go && wsel == OFS_RCAUSE)
         rcause_q <= (hwdata[7:0] & RCAUSE_WMASK)
                     | (rcause_q & ~RCAUSE_WMASK);
   end

   // ----------------------------------------
   // Control, mask and timer0 configuration
   // ----------------------------------------
   // Control enables, priorities and edge selects
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         main_q <= '0;
         ctl2_q <= CTL2_RST;
         ctl3_q <= CTL3_RST;
         mask_q <= '0;
         t0_wide_q <= 1'b0;
      end
      else if (clock_en && wr_go)
      begin
         case (wsel)
            OFS_MAIN: main_q <= {hwdata[7:3], 3'b000};
            OFS_CTL2: ctl2_q <= hwdata[7:0];
            OFS_CTL3: ctl3_q <= {hwdata[7:3], 3'b000};
            OFS_MASK: mask_q <= hwdata[EV_N-1:0];
            OFS_T0CFG: t0_wide_q <= hwdata[0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // External interrupt pins
   // ----------------------------------------
   // Three-flop synchronisers; a level counts once flops 2 and 3 agree
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         x_s1_q <= '0;
         x_s2_q <= '0;
         x_s3_q <= '0;
         x_stable_q <= '0;
         pb_s1_q <= '0;
         pb_s2_q <= '0;
         pb_s3_q <= '0;
      end
      else if (clock_en)
      begin
         x_s1_q <= ext_pins;
         x_s2_q <= x_s1_q;
         x_s3_q <= x_s2_q;
         x_stable_q <= (x_stable_q & (x_s2_q ^ x_s3_q))
                       | (x_s3_q & (x_s2_q ~^ x_s3_q));
         pb_s1_q <= portb_pins;
         pb_s2_q <= pb_s1_q;
         pb_s3_q <= pb_s2_q;
      end
   end

   // Per-pin edge select, enable and edge detect
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_ext
         assign edge_sel[gi] = ctl2_q[C2_EDGE0-gi];
         assign x_edge[gi] = (x_s2_q[gi] == x_s3_q[gi])
                             && (x_s3_q[gi] != x_stable_q[gi])
                             && (x_s3_q[gi] == edge_sel[gi]);
      end
   endgenerate

   assign x_en = {ctl3_q[C3_X1EN+2:C3_X1EN], main_q[MN_X0EN]};

   // ----------------------------------------
   // Timer0 and port-B change
   // ----------------------------------------
   // wrap detection in 8-bit or 16-bit mode
   assign t0_wrap = timer0_tick && (t0_wide_q ? (t0_cnt_q == T0_WRAP16)
                                   : (t0_cnt_q[7:0] == T0_WRAP8));

   // Timer0 counter; 8-bit mode keeps the high byte at zero
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         t0_cnt_q <= '0;
      else if (clock_en && timer0_tick)
         t0_cnt_q <= t0_wide_q ? t0_cnt_q + 16'h0001
                               : {8'h00, t0_cnt_q[7:0] + 8'h01};
   end

   // mismatch of input pins against last snapshot read
   assign pb_mismatch = |((pb_s3_q ^ pb_snap_q) & portb_is_input
                          & ~(pb_s2_q ^ pb_s3_q));

   // Snapshot refreshed by reading it, which ends a mismatch
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         pb_snap_q <= '0;
      else if (clock_en && rd_go && wsel == OFS_PBSNAP)
         pb_snap_q <= pb_s3_q;
   end

   // ----------------------------------------
   // Event flags
   // ----------------------------------------
   // event sources
   assign ev_set = {x_edge[3:1], t0_wrap, x_edge[0], pb_mismatch};
   assign ev_clr = (wr_go && wsel == OFS_STAT) ? hwdata[EV_N-1:0] : '0;

   // flags cleared only by a one written; a new event wins
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         flag_q <= '0;
      else if (clock_en)
         flag_q <= (flag_q & ~ev_clr) | ev_set;
   end

   // ----------------------------------------
   // Request forming
   // ----------------------------------------
   // source priorities
   assign src_prio = {ctl2_q[C2_X3PRIO], ctl3_q[C3_X2PRIO],
                      ctl3_q[C3_X1PRIO], ctl2_q[C2_T0PRIO], 1'b1,
                      ctl2_q[C2_PBPRIO]};
   assign src_en = {x_en[3:1], main_q[MN_T0EN], x_en[0],
                    main_q[MN_PBEN]};
   assign src_act = flag_q & src_en;
   assign p2_act = periph2_flags & periph2_enables & PRIO2_IMPL;
   assign p3_act = periph3_flags & periph3_enables & PRIO3_IMPL;
   assign priority_levels_enable = rcause_q[RC_PRIO_EN];

   always_comb
   begin
      if (priority_levels_enable)
      begin
         hi_d = main_q[MN_GIE] && (|(src_act & src_prio)
                || |(p2_act & prio2_q) || |(p3_act & prio3_q));
         lo_d = main_q[MN_PERIPHERAL_IRQ_ENABLE] && (|(src_act & ~src_prio)
                || |(p2_act & ~prio2_q) || |(p3_act & ~prio3_q));
      end
      else
      begin
         hi_d = main_q[MN_GIE] && (|src_act
                || (main_q[MN_PERIPHERAL_IRQ_ENABLE] && |{p2_act, p3_act}));
         lo_d = 1'b0;
      end
   end

   // Registered request, wake and summary interrupt outputs
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         irq_high_q <= 1'b0;
         irq_low_q <= 1'b0;
         wake_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else if (clock_en)
      begin
         irq_high_q <= hi_d;
         irq_low_q <= lo_d;
         wake_q <= |src_act;
         irq_q <= |(flag_q & mask_q);
      end
   end

   // ----------------------------------------
   // Context save
   // ----------------------------------------
   // return stack push on accept, pop on return
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         sp_q <= '0;
      else if (clock_en)
      begin
         if (core_accept && sp_q < SP_W'(STACK_D))
            sp_q <= sp_q + SP_W'(1);
         else if (core_return && !core_accept && sp_q != '0)
            sp_q <= sp_q - SP_W'(1);
      end
   end

   // Stack storage; overflow drops the push
   always_ff @(posedge clock)
   begin
      if (clock_en && core_accept && sp_q < SP_W'(STACK_D))
         stack_q[sp_q] <= core_pc;
   end

   // Top of stack and fast shadow outputs
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         stack_top_q <= '0;
         shadow_q <= '0;
      end
      else if (clock_en)
      begin
         if (core_accept)
         begin
            stack_top_q <= core_pc;
            shadow_q <= core_ctx;
         end
         else if (core_return && sp_q > SP_W'(1))
            stack_top_q <= stack_q[sp_q-SP_W'(2)];
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_ext_edge_flag: assert property (
      clock_en && x_edge[0] |=> flag_q[EV_X0])
      else $error("edge did not set ext flag");
   a_flag_sticky: assert property (
      clock_en && flag_q[EV_X1] && !ev_clr[EV_X1] |=> flag_q[EV_X1])
      else $error("ext flag cleared by hardware");
   a_ext0_high: assert property (
      clock_en && src_act[EV_X0] && main_q[MN_GIE] |=> irq_high_q)
      else $error("ext zero not high priority");
   a_legacy_no_low: assert property (
      clock_en && !priority_levels_enable |=> !irq_low_q)
      else $error("low request in single-level mode");
   a_wake_ext: assert property (
      clock_en && |(flag_q & src_en & 6'h3A) |=> wake_q)
      else $error("no wake on enabled ext flag");
   a_tmr0_wrap: assert property (
      clock_en && timer0_tick && !t0_wide_q
      && t0_cnt_q[7:0] == 8'hFF |=> flag_q[EV_T0] && t0_cnt_q == 16'h0)
      else $error("timer0 wrap missed");
   a_shadow_save: assert property (
      clock_en && core_accept |=> shadow_q == $past(core_ctx))
      else $error("shadow not saved");
   a_stack_push: assert property (
      clock_en && core_accept && sp_q < SP_W'(STACK_D)
      |=> sp_q == $past(sp_q) + SP_W'(1) && stack_top_q == $past(core_pc))
      else $error("return address not pushed");
   a_prio_bits_zero: assert property (
      prio3_q[7:6] == 2'b00 && prio2_q[7] == 1'b0 && prio2_q[5] == 1'b0)
      else $error("unimplemented priority bit set");
   a_periph_gate: assert property (
      clock_en && !priority_levels_enable && !main_q[MN_PERIPHERAL_IRQ_ENABLE] && src_act == '0 |=> !irq_high_q)
      else $error("peripheral passed without enable");
   a_read_wait: assert property (
      clock_en && take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   c_two_level: cover property (priority_levels_enable && irq_low_q ##1 irq_high_q);
   c_portb_change: cover property (clock_en && pb_mismatch);
   c_nested_push: cover property (core_accept ##[1:20] core_accept);
endmodule // ipei_ctrl

// >>> hw/ipei_pkg.sv
// Purpose: Shared constants and types of the interrupt priority block
// Assumes: AHB-Lite word registers, byte offsets below
// Notes: Offsets are byte addresses in the low eight address bits
package ipei_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_PRIO2 = 8'h00;
   localparam logic [7:0] OFS_PRIO3 = 8'h04;
   localparam logic [7:0] OFS_RCAUSE = 8'h08;
   localparam logic [7:0] OFS_MAIN = 8'h0C;
   localparam logic [7:0] OFS_CTL2 = 8'h10;
   localparam logic [7:0] OFS_CTL3 = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   localparam logic [7:0] OFS_MASK = 8'h1C;
   localparam logic [7:0] OFS_T0CFG = 8'h20;
   localparam logic [7:0] OFS_T0CNT = 8'h24;
   localparam logic [7:0] OFS_PBSNAP = 8'h28;

   // ----------------------------------------
   // Reset values and implemented bits
   // ----------------------------------------
   localparam logic [7:0] PRIO2_IMPL = 8'h5F;
   localparam logic [7:0] PRIO3_IMPL = 8'h3F;
   localparam logic [7:0] RCAUSE_RST = 8'h1C;
   localparam logic [7:0] RCAUSE_WMASK = 8'h93;
   localparam logic [7:0] CTL2_RST = 8'h7F;
   localparam logic [7:0] CTL3_RST = 8'hC0;
   localparam logic [15:0] T0_WRAP16 = 16'hFFFF;
   localparam logic [7:0] T0_WRAP8 = 8'hFF;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int RC_PRIO_EN = 7;
   localparam int MN_GIE = 7;
   localparam int MN_PERIPHERAL_IRQ_ENABLE = 6;
   localparam int MN_T0EN = 5;
   localparam int MN_X0EN = 4;
   localparam int MN_PBEN = 3;
   localparam int C2_EDGE0 = 6;
   localparam int C2_T0PRIO = 2;
   localparam int C2_X3PRIO = 1;
   localparam int C2_PBPRIO = 0;
   localparam int C3_X2PRIO = 7;
   localparam int C3_X1PRIO = 6;
   localparam int C3_X1EN = 3;

   // Event index in status and mask registers
   localparam int EV_PB = 0;
   localparam int EV_X0 = 1;
   localparam int EV_T0 = 2;
   localparam int EV_X1 = 3;
   localparam int EV_N = 6;

   // Context copied into the shadow store on interrupt entry
   typedef struct packed {
      logic [7:0] working;
      logic [7:0] status;
      logic [3:0] bank;
   } ipei_ctx_s;

   // Captured AHB address phase
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
   } ipei_req_s;
endpackage : ipei_pkg

// >>> verification/interrupt_priority_and_ext_irq_bench.sv
// Purpose: Self-checking bench of the interrupt priority block
// Assumes: Single clock, AHB-Lite master with zero-wait writes
// Notes: Read results are checked by a watcher against queued notes
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
$display("FAIL at %0t: got %0h expected %0h", $time, g, e); end end
module interrupt_priority_and_ext_irq_bench;
   import ipei_pkg::*;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout, hresp, irq_high_q, irq_low_q, wake_q, irq_q;
   logic [3:0] ext_pins = 4'h0;
   logic [7:4] portb_pins = 4'h0;
   logic [7:4] portb_is_input = 4'hF;
   logic timer0_tick = 1'b0;
   logic [7:0] p2f = 8'h00, p2e = 8'h00, p3f = 8'h00, p3e = 8'h00;
   logic core_accept, core_return, take = 1'b0, rd_ph = 1'b0;
   logic acc_pend = 1'b0, ce = 1'b1;
   logic [1:0] lag = 2'h0;
   logic [20:0] core_pc, stack_top_q, pc_s;
   ipei_ctx_s core_ctx, shadow_q, ctx_s;
   logic [31:0] exp_q[$];
   logic [31:0] exp_v;
   logic [7:0] m, rp, imp;
   logic [7:0] sbit [4] = '{8'h02, 8'h08, 8'h10, 8'h20};
   int fail_count = 0, n_checks = 0, seed = 95034, n_acc = 0, k;

   always #2 clock = ~clock;

   ipei_ctrl dut_u (.clock(clock), .reset(reset), .clock_en(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ext_pins(ext_pins),
      .portb_pins(portb_pins), .portb_is_input(portb_is_input),
      .timer0_tick(timer0_tick), .periph2_flags(p2f),
      .periph2_enables(p2e), .periph3_flags(p3f), .periph3_enables(p3e),
      .core_accept(core_accept), .core_return(core_return),
      .core_pc(core_pc), .core_ctx(core_ctx), .irq_high_q(irq_high_q),
      .irq_low_q(irq_low_q), .wake_q(wake_q), .irq_q(irq_q),
      .stack_top_q(stack_top_q), .shadow_q(shadow_q));

   ipei_core_model core_u (.clock(clock), .reset(reset),
      .irq_high_q(irq_high_q), .irq_low_q(irq_low_q), .take(take),
      .lag(lag), .core_accept(core_accept), .core_return(core_return),
      .core_pc(core_pc), .core_ctx(core_ctx));

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Waits for hready under a bounded count
   task automatic wait_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         fail_count++;
         $display("FAIL at %0t: bus wait too long", $time);
      end
   endtask

   // One single transfer; a read notes its expected word first
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      if (!w)
         exp_q.push_back({24'h00_0000, d});
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, w ? d : ~d};
      wait_rdy();
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(a, 1'b0, e);
   endtask

   // Timer0 advances once per clock while the tick is held
   task automatic run_t0(input int n);
      timer0_tick <= 1'b1;
      tick(n);
      timer0_tick <= 1'b0;
      tick(2);
   endtask

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------
   // Watcher
   // ----------------------------------------
   // Read data and accepted context against the oldest notes
   always @(posedge clock)
   begin
      if (rd_ph && hreadyout === 1'b1)
      begin
         exp_v = exp_q.pop_front();
         `CHK(hrdata, exp_v)
         `CHK(hresp, 1'b0)
      end
      if (hreadyout === 1'b1)
         rd_ph <= hsel & htrans[1] & ~hwrite;
      if (acc_pend)
      begin
         `CHK(stack_top_q, pc_s) // return address pushed
         `CHK(shadow_q, ctx_s) // context copied to shadow
      end
      if (core_accept === 1'b1)
         n_acc++;
      acc_pend <= core_accept;
      pc_s <= core_pc;
      ctx_s <= core_ctx;
   end

   // Hang guard
   initial
   begin
      #400000;
      fail_count++;
      $display("FAIL at %0t: watchdog expired", $time);
      close_out();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      // Reset values, access kinds, unmapped place
      rd(OFS_PRIO2, 8'h5F); // prio2 resets high
      rd(OFS_PRIO3, 8'h3F); // prio3 resets high
      rd(OFS_RCAUSE, 8'h1C); // levels off at reset
      rd(OFS_CTL2, 8'h7F); // default priorities
      wr(OFS_PRIO2, 8'hFF);
      wr(OFS_PRIO3, 8'hFF);
      wr(OFS_RCAUSE, 8'hFF);
      wr(8'h40, 8'hFF);
      rd(OFS_PRIO2, 8'h5F); // bits 7 and 5 zero
      rd(OFS_PRIO3, 8'h3F); // bits 7-6 zero
      rd(OFS_RCAUSE, 8'h9F); // unimplemented bits zero
      rd(8'h40, 8'h00);
      wr(OFS_RCAUSE, 8'h00);
      rd(OFS_RCAUSE, 8'h0C); // read-only flags stay set
      // Peripheral priority routing on a random source bit
      for (int r = 0; r < 2; r++)
      begin
         imp = (r == 0) ? PRIO2_IMPL : PRIO3_IMPL;
         do
            k = $unsigned($random(seed)) % 8;
         while (!imp[k]);
         m = 8'h01 << k;
         rp = (r == 0) ? OFS_PRIO2 : OFS_PRIO3;
         p2f <= (r == 0) ? m : 8'h00;
         p3f <= (r == 1) ? m : 8'h00;
         p2e <= m;
         p3e <= m;
         wr(OFS_RCAUSE, 8'h80);
         wr(OFS_MAIN, 8'hC0);
         wr(rp, imp);
         tick(3);
         `CHK({irq_high_q, irq_low_q}, 2'b10) // high level request
         wr(rp, imp & ~m);
         tick(3);
         `CHK({irq_high_q, irq_low_q}, 2'b01) // cleared bit is low
         wr(OFS_RCAUSE, 8'h00);
         wr(OFS_MAIN, 8'h80);
         tick(3);
         `CHK(irq_high_q | irq_low_q, 1'b0) // needs peripheral enable
         wr(OFS_MAIN, 8'hC0);
         tick(3);
         `CHK({irq_high_q, irq_low_q}, 2'b10) // single level
      end
      p2f <= 8'h00;
      p3f <= 8'h00;
      // External pins, both polarities on every pin
      wr(OFS_RCAUSE, 8'h80);
      wr(OFS_MAIN, 8'h00);
      for (int i = 0; i < 4; i++)
         for (int p = 1; p >= 0; p--)
         begin
            wr(OFS_CTL2, p ? 8'h7F : 8'h7F & ~(8'h40 >> i));
            ext_pins[i] <= ~p[0];
            tick(8);
            wr(OFS_STAT, 8'h3F);
            ext_pins[i] <= p[0];
            tick(8);
            rd(OFS_STAT, sbit[i]); // valid edge sets flag
            rd(OFS_STAT, sbit[i]); // hardware keeps flag
            wr(OFS_STAT, 8'h3F); // software clears flag
            ext_pins[i] <= ~p[0];
            tick(8);
            rd(OFS_STAT, 8'h00); // other edge ignored
         end
      wr(OFS_CTL2, 8'h7F);
      ext_pins <= 4'h0;
      tick(8);
      wr(OFS_STAT, 8'h3F);
      wr(OFS_MAIN, 8'h10);
      ext_pins <= 4'h3;
      tick(8);
      `CHK({wake_q, irq_high_q}, 2'b10) // wake without global enable
      wr(OFS_MAIN, 8'h90);
      tick(3);
      `CHK({irq_high_q, irq_low_q}, 2'b10) // ext zero always high
      wr(OFS_MASK, 8'h02);
      tick(3);
      `CHK(irq_q, 1'b1)
      wr(OFS_MAIN, 8'h40);
      wr(OFS_CTL3, 8'h08);
      tick(3);
      `CHK({irq_high_q, irq_low_q}, 2'b01) // disabled, low prio
      wr(OFS_MAIN, 8'hC0);
      wr(OFS_CTL3, 8'h48);
      tick(3);
      `CHK({irq_high_q, irq_low_q}, 2'b10) // ext1 priority bit
      wr(OFS_STAT, 8'h3F);
      tick(3);
      `CHK(irq_q, 1'b0)
      wr(OFS_MASK, 8'h00);
      wr(OFS_MAIN, 8'h00);
      wr(OFS_CTL3, 8'hC0);
      // Port-B change, input and output pins
      portb_pins[5] <= 1'b1;
      tick(8);
      rd(OFS_STAT, 8'h01); // change sets flag
      rd(OFS_MAIN, 8'h01); // flag shown in bit 0
      portb_pins[5] <= 1'b0;
      tick(8);
      wr(OFS_STAT, 8'h3F);
      portb_is_input[6] <= 1'b0;
      portb_pins[6] <= 1'b1;
      tick(8);
      rd(OFS_STAT, 8'h00); // output pins excluded
      // Timer0 wrap in both modes
      wr(OFS_T0CFG, 8'h01);
      run_t0(65535);
      rd(OFS_STAT, 8'h00); // no flag before wrap
      run_t0(1);
      rd(OFS_STAT, 8'h04); // 16-bit wrap flag
      wr(OFS_T0CFG, 8'h00);
      wr(OFS_STAT, 8'h3F);
      run_t0(255);
      rd(OFS_STAT, 8'h00); // no flag before wrap
      run_t0(1);
      rd(OFS_STAT, 8'h04); // 8-bit wrap flag
      ce <= 1'b0;
      run_t0(3);
      ce <= 1'b1;
      rd(OFS_T0CNT, 8'h00); // count held while frozen
      wr(OFS_MAIN, 8'hA0);
      tick(3);
      `CHK({irq_high_q, irq_low_q}, 2'b10) // timer0 high priority
      wr(OFS_CTL2, 8'h7B);
      wr(OFS_MAIN, 8'h60);
      tick(3);
      `CHK({irq_high_q, irq_low_q}, 2'b01) // timer0 low priority
      // Accept with a prompt and then a slow core
      for (int j = 0; j < 2; j++)
      begin
         lag <= j ? 2'h3 : 2'h0;
         take <= 1'b1;
         tick(12);
         take <= 1'b0;
         tick(4);
      end
      `CHK(n_acc, 2) // both entries accepted
      close_out();
   end
endmodule // interrupt_priority_and_ext_irq_bench

// >>> verification/ipei_core_model.sv
// Purpose: Core side model that accepts interrupts and returns from them
// Assumes: Requests are registered levels from the controller
// Notes: Lag sets the cycles between a request and its acceptance
`timescale 1ns/1ps
module ipei_core_model
#(
   parameter int PC_W = 21
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic irq_high_q,
   input wire logic irq_low_q,
   input wire logic take,
   input wire logic [1:0] lag,
   output logic core_accept,
   output logic core_return,
   output logic [PC_W-1:0] core_pc,
   output ipei_pkg::ipei_ctx_s core_ctx
);
   import ipei_pkg::*;

   // ----------------------------------------
   // Accept and return sequencing
   // ----------------------------------------
   int seed = 95034;
   logic busy_q;
   logic [1:0] wait_q;

   // Context is scrambled outside accepts so stale values never match
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         core_accept <= 1'b0;
         core_return <= 1'b0;
         core_pc <= '0;
         core_ctx <= '0;
         busy_q <= 1'b0;
         wait_q <= 2'h0;
      end
      else
      begin
         core_accept <= 1'b0;
         core_return <= 1'b0;
         core_pc <= ~core_pc;
         core_ctx <= ~core_ctx;
         if (!busy_q && take && (irq_high_q || irq_low_q))
         begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == lag)
            begin
               core_accept <= 1'b1;
               core_pc <= PC_W'($unsigned($random(seed)));
               core_ctx <= ipei_ctx_s'(20'($unsigned($random(seed))));
               busy_q <= 1'b1;
               wait_q <= 2'h0;
            end
         end
         else if (busy_q && !take)
         begin
            core_return <= 1'b1;
            busy_q <= 1'b0;
         end
      end
   end
endmodule // ipei_core_model
